// >>> hw/aigc_mode_decode.sv
`timescale 1ns/10ps
`include "aigc_params.svh"

module aigc_mode_decode (
    input aigc_pkg::aigc_mode_t mode,
    output logic vsb_mode_valid,
    output logic [1:0] vsb_input,
    output logic reference_on,
    output logic [1:0] output_channel_select,
    output logic mode_forces_fixed
);
    import aigc_pkg::*;

    always_comb begin
        vsb_mode_valid = 1'b1;
        vsb_input = 2'h0;
        output_channel_select = `AIGC_OUT_SEL_CH1;
        case (mode)
            6'h00: vsb_input = 2'h0;
            6'h01: vsb_input = 2'h1;
            6'h0e: vsb_input = 2'h2;
            6'h0f: vsb_input = 2'h3;
            6'h02, 6'h03, 6'h04, 6'h05: begin
                vsb_input = 2'(mode - 6'h02);
                output_channel_select = `AIGC_OUT_SEL_CH2;
            end
            6'h10, 6'h11: begin
                vsb_input = 2'(mode - 6'h10);
                output_channel_select = `AIGC_OUT_SEL_CH3;
            end
            6'h1e, 6'h1f: begin
                vsb_input = 2'(mode - 6'h1c);
                output_channel_select = `AIGC_OUT_SEL_CH3;
            end
            6'h12, 6'h13, 6'h14, 6'h15: begin
                vsb_input = 2'(mode - 6'h12);
                output_channel_select = `AIGC_OUT_SEL_CH4;
            end
            default: vsb_mode_valid = 1'b0;
        endcase
        // vsb codes carry a fixed reference and fixed gain
        reference_on = vsb_mode_valid;
        mode_forces_fixed = vsb_mode_valid;
    end
endmodule : aigc_mode_decode

// >>> hw/aigc_params.svh
`ifndef AIGC_PARAMS_SVH
`define AIGC_PARAMS_SVH

// subaddresses
`define AIGC_SUB_MODE 8'h02
`define AIGC_SUB_CTRL 8'h03
`define AIGC_SUB_GAIN1 8'h04
`define AIGC_SUB_GAIN2 8'h05

// reset values
`define AIGC_RST_MODE 8'h00
`define AIGC_RST_CTRL 7'h00
`define AIGC_RST_GAIN 8'h00

// fields of clamp_gain_behaviour and the top bit of input_mode
`define AIGC_CTRL_W 7
`define AIGC_BIT_CLAMP 6
`define AIGC_BIT_VBLANK 5
`define AIGC_BIT_PEAK_OFF 4
`define AIGC_BIT_HOLD 3
`define AIGC_BIT_FIX 2
`define AIGC_BIT_G2MSB 1
`define AIGC_BIT_G1MSB 0
`define AIGC_MODE_HI 5

// output-select values
`define AIGC_OUT_SEL_CH1 2'h0
`define AIGC_OUT_SEL_CH2 2'h1
`define AIGC_OUT_SEL_CH3 2'h2
`define AIGC_OUT_SEL_CH4 2'h3

// first line of active video
`define AIGC_ACTIVE_LINE_60 10'h016
`define AIGC_ACTIVE_LINE_50 10'h018

// static gain scale, gain in hundredths of a dB
`define AIGC_GAIN_UNITY 144
`define AIGC_GAIN_FULL 511
`define AIGC_CDB_LOW 300
`define AIGC_CDB_HIGH 600
`define AIGC_GAIN_UNITY_CODE 9'h090
`define AIGC_GAIN_FULL_CODE 9'h1ff

`endif

// >>> hw/aigc_pkg.sv
package aigc_pkg;
    typedef logic [5:0] aigc_mode_t;
    typedef logic [8:0] aigc_gain_t;
    typedef logic signed [10:0] aigc_cdb_t;
    typedef enum logic [1:0] {
        AIGC_RUN = 2'b00,
        AIGC_LONG_HOLD = 2'b01
    } aigc_agc_state_e;
endpackage : aigc_pkg

// >>> hw/aigc_regs.sv
`timescale 1ns/10ps
`include "aigc_params.svh"

// Operation
// - vsb channel 1 codes: ref, select 0, fixed
// - codes 02-05: channel 2, ref, select 1
// - channel 3 codes: ref, select 2, fixed
// - codes 12-15: channel 4, ref, select 3
// - bit 6 picks clamping while unlocked
// - bit 5 clear: hold during equalization only
// - bit 5 set: hold until active video
// - bit 4 clear attenuates overrange, set disables
// - bit 3 freezes gain integrator
// - bit 2 selects static gain words
// - channel 1 gain is 03h[0] then 04h
// - channel 2 gain is 03h[1] then 05h
// - gain code maps monotonically -3 to +6 dB
module aigc_regs (
    input logic clk,
    input logic rst,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_subaddr,
    input logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input logic decoder_locked,
    input logic field_60hz,
    input logic [9:0] line_number,
    input logic pre_eq_start,
    input logic eq_serration_active,
    input logic adc_over_max,
    output aigc_pkg::aigc_mode_t input_mode,
    output logic vsb_mode_valid,
    output logic [1:0] vsb_input,
    output logic reference_on,
    output logic [1:0] output_channel_select,
    output logic fixed_gain_select,
    output logic unlocked_clamp_choice,
    output logic clamp_reference_select,
    output logic blanking_length_select,
    output logic colour_peak_disable,
    output logic colour_attenuate,
    output logic gain_integrator_freeze,
    output logic agc_update_enable,
    output aigc_pkg::aigc_gain_t gain_ch1,
    output aigc_pkg::aigc_gain_t gain_ch2,
    output aigc_pkg::aigc_cdb_t gain_ch1_cdb,
    output aigc_pkg::aigc_cdb_t gain_ch2_cdb
);
    import aigc_pkg::*;

    logic [7:0] input_mode_select;
    logic [`AIGC_CTRL_W-1:0] clamp_gain_behaviour;
    logic [7:0] static_gain_ch1_low;
    logic [7:0] static_gain_ch2_low;
    logic mode_forces_fixed;
    logic [9:0] active_line;
    aigc_agc_state_e agc_state;
    aigc_agc_state_e next_agc_state;

    // piecewise linear so 0, 144 and 511 land exactly on -3, 0 and +6 dB
    function automatic aigc_cdb_t gain_to_cdb(input aigc_gain_t code);
        int c;
        int r;
        c = int'(code);
        if (c <= `AIGC_GAIN_UNITY) begin
            r = (c * `AIGC_CDB_LOW) / `AIGC_GAIN_UNITY - `AIGC_CDB_LOW;
        end else begin
            r = ((c - `AIGC_GAIN_UNITY) * `AIGC_CDB_HIGH)
                / (`AIGC_GAIN_FULL - `AIGC_GAIN_UNITY);
        end
        return aigc_cdb_t'(r);
    endfunction : gain_to_cdb

    function automatic logic hit(input logic [7:0] sub, input logic [7:0] target);
        return sub == target;
    endfunction : hit

    // register writes
    always_ff @(posedge clk) begin
        if (rst) begin
            input_mode_select <= `AIGC_RST_MODE;
            clamp_gain_behaviour <= `AIGC_RST_CTRL;
            static_gain_ch1_low <= `AIGC_RST_GAIN;
            static_gain_ch2_low <= `AIGC_RST_GAIN;
        end else if (reg_wr) begin
            if (hit(reg_subaddr, `AIGC_SUB_MODE)) begin
                input_mode_select <= reg_wdata;
            end
            if (hit(reg_subaddr, `AIGC_SUB_CTRL)) begin
                clamp_gain_behaviour <= reg_wdata[`AIGC_CTRL_W-1:0];
            end
            if (hit(reg_subaddr, `AIGC_SUB_GAIN1)) begin
                static_gain_ch1_low <= reg_wdata;
            end
            if (hit(reg_subaddr, `AIGC_SUB_GAIN2)) begin
                static_gain_ch2_low <= reg_wdata;
            end
        end
    end

    // read path; bit 7 of 03h is unused and unmapped subaddresses read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_subaddr)
                    `AIGC_SUB_MODE: reg_rdata <= input_mode_select;
                    `AIGC_SUB_CTRL: reg_rdata <= {1'b0, clamp_gain_behaviour};
                    `AIGC_SUB_GAIN1: reg_rdata <= static_gain_ch1_low;
                    `AIGC_SUB_GAIN2: reg_rdata <= static_gain_ch2_low;
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

    assign input_mode = input_mode_select[`AIGC_MODE_HI:0];

    aigc_mode_decode aigc_mode_decode_inst (
        .mode(input_mode),
        .vsb_mode_valid(vsb_mode_valid),
        .vsb_input(vsb_input),
        .reference_on(reference_on),
        .output_channel_select(output_channel_select),
        .mode_forces_fixed(mode_forces_fixed)
    );

    // control bits act straight from the register flops
    assign unlocked_clamp_choice = clamp_gain_behaviour[`AIGC_BIT_CLAMP];
    assign blanking_length_select = clamp_gain_behaviour[`AIGC_BIT_VBLANK];
    assign colour_peak_disable = clamp_gain_behaviour[`AIGC_BIT_PEAK_OFF];
    assign gain_integrator_freeze = clamp_gain_behaviour[`AIGC_BIT_HOLD];
    assign fixed_gain_select = clamp_gain_behaviour[`AIGC_BIT_FIX] | mode_forces_fixed;

    assign clamp_reference_select = unlocked_clamp_choice & ~decoder_locked;
    assign colour_attenuate = ~colour_peak_disable & adc_over_max;

    assign gain_ch1 = {clamp_gain_behaviour[`AIGC_BIT_G1MSB], static_gain_ch1_low};
    assign gain_ch2 = {clamp_gain_behaviour[`AIGC_BIT_G2MSB], static_gain_ch2_low};
    assign gain_ch1_cdb = gain_to_cdb(gain_ch1);
    assign gain_ch2_cdb = gain_to_cdb(gain_ch2);

    // long vertical blanking hold
    assign active_line = field_60hz ? `AIGC_ACTIVE_LINE_60 : `AIGC_ACTIVE_LINE_50;

    always_comb begin
        next_agc_state = agc_state;
        case (agc_state)
            AIGC_RUN: begin
                if (blanking_length_select && pre_eq_start) begin
                    next_agc_state = AIGC_LONG_HOLD;
                end
            end
            AIGC_LONG_HOLD: begin
                // clearing bit 5 mid-hold returns to AIGC_RUN on the next clock, without waiting for active video
                if (!blanking_length_select || line_number == active_line) begin
                    next_agc_state = AIGC_RUN;
                end
            end
            default: next_agc_state = AIGC_RUN;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            agc_state <= AIGC_RUN;
        end else begin
            agc_state <= next_agc_state;
        end
    end

    // short mode holds only while the equalization/serration pulses last
    assign agc_update_enable = ~gain_integrator_freeze
        & (agc_state == AIGC_RUN)
        & ~(~blanking_length_select & eq_serration_active);

    AST_CH1_MODES: assert property (@(posedge clk) disable iff (rst)
        (input_mode inside {6'h00, 6'h01, 6'h0e, 6'h0f}) |->
        reference_on && output_channel_select == 2'h0 && fixed_gain_select
        && vsb_input == input_mode[1:0])
        else $error("channel 1 vsb decode wrong");

    AST_CH2_MODES: assert property (@(posedge clk) disable iff (rst)
        (input_mode inside {[6'h02:6'h05]}) |->
        reference_on && output_channel_select == 2'h1 && fixed_gain_select
        && vsb_input == 2'(input_mode - 6'h02))
        else $error("channel 2 vsb decode wrong");

    AST_CH3_MODES: assert property (@(posedge clk) disable iff (rst)
        (input_mode inside {6'h10, 6'h11, 6'h1e, 6'h1f}) |->
        reference_on && output_channel_select == 2'h2 && fixed_gain_select
        && vsb_input == input_mode[1:0])
        else $error("channel 3 vsb decode wrong");

    AST_CH4_MODES: assert property (@(posedge clk) disable iff (rst)
        (input_mode inside {[6'h12:6'h15]}) |->
        reference_on && output_channel_select == 2'h3 && fixed_gain_select
        && vsb_input == 2'(input_mode - 6'h12))
        else $error("channel 4 vsb decode wrong");

    AST_UNLOCKED_CLAMP: assert property (@(posedge clk) disable iff (rst)
        decoder_locked |-> !clamp_reference_select)
        else $error("reference clamp while locked");

    AST_SHORT_BLANK: assert property (@(posedge clk) disable iff (rst)
        (!blanking_length_select && eq_serration_active) |-> !agc_update_enable)
        else $error("agc updating during equalization");

    AST_LONG_START: assert property (@(posedge clk) disable iff (rst)
        (agc_state == AIGC_RUN && blanking_length_select && pre_eq_start && !reg_wr)
        |=> !agc_update_enable)
        else $error("long blanking hold did not start");

    AST_LONG_END: assert property (@(posedge clk) disable iff (rst)
        (agc_state == AIGC_LONG_HOLD && line_number == active_line)
        |=> agc_state == AIGC_RUN)
        else $error("long blanking hold did not end at active video");

    AST_PEAK: assert property (@(posedge clk) disable iff (rst)
        (adc_over_max && !clamp_gain_behaviour[`AIGC_BIT_PEAK_OFF]) |-> colour_attenuate)
        else $error("overrange not attenuated");

    AST_FREEZE: assert property (@(posedge clk) disable iff (rst)
        clamp_gain_behaviour[`AIGC_BIT_HOLD] |-> !agc_update_enable)
        else $error("agc running while frozen");

    AST_GAIN1_WRITE: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_subaddr == `AIGC_SUB_GAIN1) |=> gain_ch1[7:0] == $past(reg_wdata))
        else $error("channel 1 gain low byte not applied");

    AST_GAIN2_MSB: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_subaddr == `AIGC_SUB_CTRL) |=> gain_ch2[8] == $past(reg_wdata[1]))
        else $error("channel 2 gain msb not applied");

    AST_GAIN_SCALE: assert property (@(posedge clk) disable iff (rst)
        (gain_ch1 == `AIGC_GAIN_UNITY_CODE |-> gain_ch1_cdb == 11'sd0)
        and (gain_ch1 == `AIGC_GAIN_FULL_CODE |-> gain_ch1_cdb == 11'sd600)
        and (gain_ch1 == 9'h000 |-> gain_ch1_cdb == -11'sd300))
        else $error("static gain scale wrong");

    AST_READBACK: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_subaddr == `AIGC_SUB_MODE) ##1 !reg_wr
        ##1 (reg_rd && reg_subaddr == `AIGC_SUB_MODE && !reg_wr)
        |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3))
        else $error("readback differs from write");

    AST_FIXED_GAIN: assert property (@(posedge clk) disable iff (rst)
        (clamp_gain_behaviour[`AIGC_BIT_FIX] || mode_forces_fixed) |-> fixed_gain_select)
        else $error("static gain not selected");

    AST_AUTO_GAIN: assert property (@(posedge clk) disable iff (rst)
        (!clamp_gain_behaviour[`AIGC_BIT_FIX] && !vsb_mode_valid) |-> !fixed_gain_select)
        else $error("automatic gain not selected");

    AST_GAIN1_MSB: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_subaddr == `AIGC_SUB_CTRL) |=> gain_ch1[8] == $past(reg_wdata[0]))
        else $error("channel 1 gain msb not applied");

    AST_GAIN2_WRITE: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && reg_subaddr == `AIGC_SUB_GAIN2) |=> gain_ch2[7:0] == $past(reg_wdata))
        else $error("channel 2 gain low byte not applied");

    AST_CLAMP_REF: assert property (@(posedge clk) disable iff (rst)
        (unlocked_clamp_choice && !decoder_locked) |-> clamp_reference_select)
        else $error("reference clamp missing while unlocked");

    AST_PEAK_OFF: assert property (@(posedge clk) disable iff (rst)
        colour_peak_disable |-> !colour_attenuate)
        else $error("attenuation while colour peak control off");

    AST_AGC_RUNS: assert property (@(posedge clk) disable iff (rst)
        (agc_state == AIGC_RUN && !gain_integrator_freeze && !eq_serration_active)
        |-> agc_update_enable)
        else $error("agc held outside blanking");

    AST_RVALID_ON: assert property (@(posedge clk) disable iff (rst)
        reg_rd |=> reg_rvalid)
        else $error("read not answered");

    AST_RVALID_ONLY: assert property (@(posedge clk) disable iff (rst)
        reg_rvalid |-> $past(reg_rd))
        else $error("read answer without request");

    AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (rst)
        (reg_wr && !(reg_subaddr inside {[`AIGC_SUB_MODE:`AIGC_SUB_GAIN2]}))
        |=> $stable(input_mode_select) && $stable(clamp_gain_behaviour)
        && $stable(static_gain_ch1_low) && $stable(static_gain_ch2_low))
        else $error("unmapped write changed a register");

    AST_CTRL_TOP_ZERO: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && reg_subaddr == `AIGC_SUB_CTRL) |=> reg_rdata[7] == 1'b0)
        else $error("unused control bit read back set");

    COV_VSB_CH4: cover property (@(posedge clk) disable iff (rst)
        vsb_mode_valid && output_channel_select == 2'h3);
    COV_LONG_HOLD: cover property (@(posedge clk) disable iff (rst)
        agc_state == AIGC_LONG_HOLD ##[1:300] agc_state == AIGC_RUN);
    COV_UNLOCKED_REF: cover property (@(posedge clk) disable iff (rst)
        clamp_reference_select);
    COV_STATIC_GAIN: cover property (@(posedge clk) disable iff (rst)
        fixed_gain_select && !vsb_mode_valid);
endmodule : aigc_regs

// >>> tb/aigc_host.sv
`timescale 1ns/10ps

module aigc_host (
    input logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_subaddr,
    output logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_subaddr = 8'h00;
        reg_wdata = 8'h00;
    end

    // one byte per strobe; released lines show inverted junk, not the old value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_subaddr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_subaddr = ~a;
        reg_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        @(negedge clk);
        reg_subaddr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_subaddr = ~a;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        ok = (reg_rvalid === 1'b1);
        d = reg_rdata;
    endtask : rd
endmodule : aigc_host

// >>> tb/tb_aigc_regs.sv
`timescale 1ns/10ps
`include "aigc_params.svh"

module tb_aigc_regs;
    import aigc_pkg::*;
    logic clk, rst, reg_wr, reg_rd, reg_rvalid, decoder_locked, field_60hz;
    logic pre_eq_start, eq_serration_active, adc_over_max;
    logic [7:0] reg_subaddr, reg_wdata, reg_rdata;
    logic [9:0] line_number;
    aigc_mode_t input_mode;
    logic vsb_mode_valid, reference_on, fixed_gain_select, unlocked_clamp_choice;
    logic clamp_reference_select, blanking_length_select, colour_peak_disable;
    logic colour_attenuate, gain_integrator_freeze, agc_update_enable;
    logic [1:0] vsb_input, output_channel_select;
    aigc_gain_t gain_ch1, gain_ch2, g1, g2;
    aigc_cdb_t gain_ch1_cdb, gain_ch2_cdb;
    int failures = 0;
    int checked = 0;
    aigc_mode_t codes [16] = '{6'h00, 6'h01, 6'h0e, 6'h0f, 6'h02, 6'h03, 6'h04, 6'h05,
        6'h10, 6'h11, 6'h1e, 6'h1f, 6'h12, 6'h13, 6'h14, 6'h15};
    aigc_gain_t gvals [3] = '{9'h000, 9'h090, 9'h1ff};
    aigc_cdb_t cdbs [3] = '{-300, 0, 600};

    aigc_regs aigc_regs_inst (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_subaddr(reg_subaddr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .decoder_locked(decoder_locked), .field_60hz(field_60hz),
        .line_number(line_number), .pre_eq_start(pre_eq_start),
        .eq_serration_active(eq_serration_active), .adc_over_max(adc_over_max),
        .input_mode(input_mode), .vsb_mode_valid(vsb_mode_valid), .vsb_input(vsb_input),
        .reference_on(reference_on), .output_channel_select(output_channel_select),
        .fixed_gain_select(fixed_gain_select), .unlocked_clamp_choice(unlocked_clamp_choice),
        .clamp_reference_select(clamp_reference_select),
        .blanking_length_select(blanking_length_select),
        .colour_peak_disable(colour_peak_disable), .colour_attenuate(colour_attenuate),
        .gain_integrator_freeze(gain_integrator_freeze),
        .agc_update_enable(agc_update_enable), .gain_ch1(gain_ch1), .gain_ch2(gain_ch2),
        .gain_ch1_cdb(gain_ch1_cdb), .gain_ch2_cdb(gain_ch2_cdb));

    aigc_host aigc_host_inst (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_subaddr(reg_subaddr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        aigc_host_inst.rd(a, d, ok);
        chk("read_valid", ok, 1'b1);
        if (!ok) begin
            print_verdict();
        end
        chk("read", {a, d}, {a, exp});
    endtask : rdchk

    // long hold entered by a pre-equalization pulse, left at the first active line
    task automatic long_hold(input logic f60, input logic [9:0] ln);
        field_60hz = f60;
        @(negedge clk);
        pre_eq_start = 1'b1;
        @(negedge clk);
        pre_eq_start = 1'b0;
        chk("agc_long_on", agc_update_enable, 1'b0);
        line_number = ln - 10'h001;
        @(negedge clk);
        chk("agc_long_early", agc_update_enable, 1'b0);
        line_number = ln;
        @(negedge clk);
        chk("agc_long_end", agc_update_enable, 1'b1);
        line_number = 10'h000;
    endtask : long_hold

    initial begin
        rst = 1'b1;
        decoder_locked = 1'b0;
        field_60hz = 1'b0;
        line_number = 10'h000;
        pre_eq_start = 1'b0;
        eq_serration_active = 1'b0;
        adc_over_max = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        chk("rst_mode", {reference_on, fixed_gain_select, output_channel_select}, 4'hc);
        for (int a = 2; a < 6; a++) rdchk(8'(a), 8'h00);
        for (int i = 0; i < 16; i++) begin
            aigc_host_inst.wr(`AIGC_SUB_MODE, {2'b00, codes[i]});
            chk("mode", {vsb_mode_valid, reference_on, fixed_gain_select, output_channel_select,
                vsb_input, input_mode},
                {3'b111, 2'(i / 4), 2'(i % 4), codes[i]});
        end
        aigc_host_inst.wr(`AIGC_SUB_MODE, 8'h16);
        chk("yc_mode", {vsb_mode_valid, reference_on, fixed_gain_select}, 3'h0);
        rdchk(`AIGC_SUB_MODE, 8'h16);
        aigc_host_inst.wr(8'h09, 8'h80);
        rdchk(8'h09, 8'h00);
        aigc_host_inst.wr(`AIGC_SUB_CTRL, 8'h04);
        chk("fix", fixed_gain_select, 1'b1);
        aigc_host_inst.wr(`AIGC_SUB_CTRL, 8'h40);
        chk("clamp_unlk", clamp_reference_select, 1'b1);
        chk("peak_on", colour_attenuate, 1'b1);
        decoder_locked = 1'b1;
        @(negedge clk);
        chk("clamp_lock", clamp_reference_select, 1'b0);
        aigc_host_inst.wr(`AIGC_SUB_CTRL, 8'hff);
        chk("ctrl_bits", {unlocked_clamp_choice, blanking_length_select, colour_peak_disable,
            gain_integrator_freeze, fixed_gain_select}, 5'h1f);
        chk("peak_off", colour_attenuate, 1'b0);
        chk("agc_freeze", agc_update_enable, 1'b0);
        rdchk(`AIGC_SUB_CTRL, 8'h7f);
        for (int i = 0; i < 3; i++) begin
            g1 = gvals[i];
            g2 = gvals[2 - i];
            aigc_host_inst.wr(`AIGC_SUB_CTRL, {6'h00, g2[8], g1[8]});
            aigc_host_inst.wr(`AIGC_SUB_GAIN1, g1[7:0]);
            aigc_host_inst.wr(`AIGC_SUB_GAIN2, g2[7:0]);
            chk("gain1", gain_ch1, g1);
            chk("gain2", gain_ch2, g2);
            chk("cdb1", 16'(gain_ch1_cdb), 16'(cdbs[i]));
            chk("cdb2", 16'(gain_ch2_cdb), 16'(cdbs[2 - i]));
        end
        // short blanking: the pulse alone must not hold the loop
        aigc_host_inst.wr(`AIGC_SUB_CTRL, 8'h00);
        @(negedge clk);
        pre_eq_start = 1'b1;
        @(negedge clk);
        pre_eq_start = 1'b0;
        chk("agc_short_pulse", agc_update_enable, 1'b1);
        eq_serration_active = 1'b1;
        @(negedge clk);
        chk("agc_short_eq", agc_update_enable, 1'b0);
        eq_serration_active = 1'b0;
        aigc_host_inst.wr(`AIGC_SUB_CTRL, 8'h20);
        long_hold(1'b1, `AIGC_ACTIVE_LINE_60);
        long_hold(1'b0, `AIGC_ACTIVE_LINE_50);
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        rdchk(`AIGC_SUB_CTRL, 8'h00);
        print_verdict();
    end
endmodule : tb_aigc_regs
